// >>> src/lockq_defs.svh
// constants for the bus lock and queue status block
`ifndef LOCKQ_DEFS_SVH
`define LOCKQ_DEFS_SVH
`define QS_NONE   2'h0
`define QS_FIRST  2'h1
`define QS_FLUSH  2'h2
`define QS_SUBSEQ 2'h3
`define LOCK_IDLE 1'h1
`define MODE_SYNC_STAGES 2
`endif

// >>> src/lockq_pkg.sv
// types for the bus lock and queue status block
package lockq_pkg;
    typedef struct packed {
        logic flush;
        logic first_byte;
        logic next_byte;
    } queue_op_s;

    typedef struct packed {
        logic t2;
        logic irq_ack_cycle;
        logic cycle_end;
    } bus_state_s;

    typedef enum logic [2:0] {
        LK_IDLE  = 3'b001,
        LK_PREF  = 3'b010,
        LK_IRQ   = 3'b100
    } lock_state_e;
endpackage

// >>> src/queue_status_enc.sv
// encoder of the two-bit queue status, registered one cycle after the queue operation
`timescale 1ns/1ps
`include "lockq_defs.svh"
module queue_status_enc (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire lockq_pkg::queue_op_s op,
    output logic [1:0]                status_q
);
    logic [1:0] status_d;

    // flush has priority over a byte fetch in the same cycle
    assign status_d = op.flush      ? `QS_FLUSH  :
                      op.first_byte ? `QS_FIRST  :
                      op.next_byte  ? `QS_SUBSEQ :
                                      `QS_NONE;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_q <= `QS_NONE;
        end else begin
            status_q <= status_d;
        end
    end

    flush_code_a: assert property (@(posedge clk) disable iff (!reset_n)
        op.flush |=> status_q == `QS_FLUSH) else $error("flush not reported");
    first_code_a: assert property (@(posedge clk) disable iff (!reset_n)
        op.first_byte && !op.flush |=> status_q == `QS_FIRST) else $error("first byte not reported");
    next_code_a: assert property (@(posedge clk) disable iff (!reset_n)
        op.next_byte && !op.flush && !op.first_byte |=> status_q == `QS_SUBSEQ)
        else $error("subsequent byte not reported");
endmodule

// >>> src/lock_queue_status.sv
// maximum-mode bus lock and queue status outputs
//
// Summary of operation
// - lock prefix drives bus lock low until the following instruction completes.
// - during a bus grant sequence bus lock floats as weak one.
// - bus lock asserts at T2 of first acknowledge, releases at second's T2.
// - queue status appears the cycle after the queue operation.
// - both queue status outputs are always driven, never floated.
// - codes: 00 none, 01 first opcode byte, 10 queue flushed, 11 subsequent byte.
`timescale 1ns/1ps
`include "lockq_defs.svh"
module lock_queue_status #(
    parameter int SYNC_STAGES = `MODE_SYNC_STAGES
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  lock_prefix,
    input  wire logic                  instr_done,
    input  wire logic                  grant_active,
    input  wire logic                  min_max_select,
    input  wire lockq_pkg::bus_state_s bus,
    input  wire lockq_pkg::queue_op_s  queue_op,
    output logic                       bus_lock_n_o,
    output logic                       bus_lock_n_oe,
    output logic                       bus_lock_weak_pu,
    output logic                       queue_state_hi,
    output logic                       queue_state_lo
);
    lockq_pkg::lock_state_e state_q;
    lockq_pkg::lock_state_e state_d;
    logic                   prefix_armed_q;
    logic                   prefix_armed_d;
    logic                   ack_second_q;
    logic                   ack_second_d;
    logic [1:0]             qs_q;
    logic                   max_mode;
    logic                   ack_t2;
    logic                   lock_active;
    logic [SYNC_STAGES-1:0] mode_sync_q;
    logic                   mode_pin_sync;
    logic                   prefix_release;
    logic                   ack_leave;
    logic                   ack_second_mark;
    logic                   lock_n_d;
    logic                   lock_oe_d;
    logic                   lock_pu_d;

    // the logic reads only the last stage; fewer than two stages leave the strap unsynchronised, so they are refused
    if (SYNC_STAGES < 2) begin : g_sync_check
        $error("SYNC_STAGES below 2 leaves the mode strap unsynchronised");
    end

    // the mode strap is a pin: it passes a flop chain before any logic reads it;
    // no reset, so the strap has settled by the time reset is released
    always_ff @(posedge clk) begin
        mode_sync_q[0] <= min_max_select;
    end

    for (genvar i = 1; i < SYNC_STAGES; i++) begin : g_mode_sync
        always_ff @(posedge clk) begin
            mode_sync_q[i] <= mode_sync_q[i-1];
        end
    end

    assign mode_pin_sync = mode_sync_q[SYNC_STAGES-1];

    // max mode is selected by a low level on the mode select input
    assign max_mode        = !mode_pin_sync;
    assign ack_t2          = max_mode && bus.irq_ack_cycle && bus.t2;
    assign ack_leave       = ack_t2 && ack_second_q;
    assign ack_second_mark = bus.cycle_end && bus.irq_ack_cycle;
    // an instr_done in the prefix's own cycle does not count as the following instruction
    assign prefix_release  = instr_done && prefix_armed_q;

    // prefix stays armed through the prefix's own completion, ends after the next
    always_comb begin
        prefix_armed_d = prefix_armed_q;
        if (lock_prefix) begin
            prefix_armed_d = 1'b1;
        end else if (prefix_release) begin
            prefix_armed_d = 1'b0;
        end
    end

    // acknowledge lock: entered at T2 of the first cycle, left at T2 once a cycle end was seen
    always_comb begin
        state_d      = state_q;
        ack_second_d = ack_second_q;
        case (state_q)
            lockq_pkg::LK_IDLE: begin
                if (ack_t2) begin
                    state_d      = lockq_pkg::LK_IRQ;
                    ack_second_d = 1'b0;
                end else if (lock_prefix) begin
                    state_d = lockq_pkg::LK_PREF;
                end
            end
            lockq_pkg::LK_PREF: begin
                if (ack_t2) begin
                    state_d      = lockq_pkg::LK_IRQ;
                    ack_second_d = 1'b0;
                end else if (!prefix_armed_d) begin
                    state_d = lockq_pkg::LK_IDLE;
                end
            end
            lockq_pkg::LK_IRQ: begin
                if (ack_leave) begin
                    // next prefix state: a prefix seen in this very cycle keeps the bus locked
                    state_d      = prefix_armed_d ? lockq_pkg::LK_PREF : lockq_pkg::LK_IDLE;
                    ack_second_d = 1'b0;
                end else if (ack_second_mark) begin
                    ack_second_d = 1'b1;
                end
            end
            default: begin
                state_d      = lockq_pkg::LK_IDLE;
                ack_second_d = 1'b0;
            end
        endcase
    end

    assign lock_active = state_d != lockq_pkg::LK_IDLE;
    // in a grant sequence the pin is released and the weak pull-up shows a one
    assign lock_n_d    = grant_active ? `LOCK_IDLE : !lock_active;
    assign lock_oe_d   = !grant_active;
    assign lock_pu_d   = grant_active;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q          <= lockq_pkg::LK_IDLE;
            prefix_armed_q   <= 1'b0;
            ack_second_q     <= 1'b0;
            bus_lock_n_o     <= `LOCK_IDLE;
            bus_lock_n_oe    <= 1'b1;
            bus_lock_weak_pu <= 1'b0;
        end else begin
            state_q          <= state_d;
            prefix_armed_q   <= prefix_armed_d;
            ack_second_q     <= ack_second_d;
            bus_lock_n_o     <= lock_n_d;
            bus_lock_n_oe    <= lock_oe_d;
            bus_lock_weak_pu <= lock_pu_d;
        end
    end

    queue_status_enc u_qs (
        .clk      (clk),
        .reset_n  (reset_n),
        .op       (queue_op),
        .status_q (qs_q)
    );

    // the encoder register drives the pins, so the code shows in the cycle after the operation;
    // the pins have no enable and are driven in every state, grant included
    assign queue_state_hi = qs_q[1];
    assign queue_state_lo = qs_q[0];

    // lock pin: driven outside grant, floating as weak one inside
    grant_float_a: assert property (@(posedge clk) disable iff (!reset_n)
        grant_active |=> !bus_lock_n_oe && bus_lock_weak_pu && bus_lock_n_o)
        else $error("lock driven in grant");
    lock_driven_a: assert property (@(posedge clk) disable iff (!reset_n)
        !grant_active |=> bus_lock_n_oe && !bus_lock_weak_pu)
        else $error("lock not driven outside grant");

    // prefix lock
    prefix_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
        lock_prefix && !grant_active |=> !bus_lock_n_o)
        else $error("prefix did not lock");
    prefix_arm_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == lockq_pkg::LK_IDLE && lock_prefix |=> prefix_armed_q)
        else $error("prefix not armed");
    prefix_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == lockq_pkg::LK_PREF && !instr_done && !ack_t2 && !grant_active |=> !bus_lock_n_o)
        else $error("lock dropped early");
    prefix_release_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == lockq_pkg::LK_PREF && prefix_release && !lock_prefix && !ack_t2 && !grant_active
        |=> bus_lock_n_o) else $error("lock held past the following instruction");

    // acknowledge lock
    ack_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
        ack_t2 && state_q != lockq_pkg::LK_IRQ && !grant_active |=> !bus_lock_n_o)
        else $error("acknowledge did not lock");
    ack_enter_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q != lockq_pkg::LK_IRQ && ack_t2 |=> state_q == lockq_pkg::LK_IRQ && !ack_second_q)
        else $error("acknowledge lock not entered");
    ack_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == lockq_pkg::LK_IRQ && !ack_leave && !grant_active |=> !bus_lock_n_o)
        else $error("acknowledge lock dropped early");
    second_mark_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == lockq_pkg::LK_IRQ && ack_second_mark && !ack_leave |=> ack_second_q)
        else $error("second acknowledge not noted");
    ack_release_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == lockq_pkg::LK_IRQ && ack_leave && !prefix_armed_q && !lock_prefix
        |=> state_q == lockq_pkg::LK_IDLE) else $error("second acknowledge did not release");
    irq_to_prefix_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == lockq_pkg::LK_IRQ && ack_leave && (lock_prefix || (prefix_armed_q && !prefix_release))
        |=> state_q == lockq_pkg::LK_PREF) else $error("prefix lock lost at acknowledge end");
    min_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        !max_mode && state_q == lockq_pkg::LK_IDLE && !lock_prefix |=> state_q == lockq_pkg::LK_IDLE)
        else $error("auto lock in min mode");

    // queue status pins
    qs_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
        queue_op.flush |=> queue_state_hi && !queue_state_lo)
        else $error("flush code late");
    qs_driven_a: assert property (@(posedge clk) disable iff (!reset_n)
        grant_active && queue_op.first_byte && !queue_op.flush |=> !queue_state_hi && queue_state_lo)
        else $error("queue status not driven in grant");
    qs_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        !queue_op.flush && !queue_op.first_byte && !queue_op.next_byte |=> !queue_state_hi && !queue_state_lo)
        else $error("idle queue code wrong");
    qs_next_a: assert property (@(posedge clk) disable iff (!reset_n)
        queue_op.next_byte && !queue_op.flush && !queue_op.first_byte |=> queue_state_hi && queue_state_lo)
        else $error("subsequent byte code wrong");

    prefix_c: cover property (@(posedge clk) disable iff (!reset_n) lock_prefix ##[1:20] instr_done);
    ack_c: cover property (@(posedge clk) disable iff (!reset_n) state_q == lockq_pkg::LK_IRQ ##1 state_q == lockq_pkg::LK_IDLE);
    grant_c: cover property (@(posedge clk) disable iff (!reset_n) grant_active && state_q != lockq_pkg::LK_IDLE);
    flush_c: cover property (@(posedge clk) disable iff (!reset_n) queue_state_hi && !queue_state_lo);
    next_byte_c: cover property (@(posedge clk) disable iff (!reset_n) queue_state_hi && queue_state_lo);
endmodule

// >>> verification/queue_tracker.sv
// far-side model that follows the prefetch queue from the status code
`timescale 1ns/1ps
module queue_tracker (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       queue_state_hi,
    input  wire logic       queue_state_lo,
    output logic      [7:0] taken_q
);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            taken_q <= 8'h00;
        end else if ({queue_state_hi, queue_state_lo} == 2'h2) begin
            taken_q <= 8'h00;
        end else if (queue_state_lo) begin
            taken_q <= taken_q + 8'h01;
        end
    end
endmodule

// >>> verification/lock_queue_status_tb_top.sv
// testbench of the bus lock and queue status block
`timescale 1ns/1ps
module lock_queue_status_tb_top;
    logic                  clk = 1'b0;
    logic                  reset_n = 1'b0;
    logic                  lock_prefix = 1'b0;
    logic                  instr_done = 1'b0;
    logic                  grant_active = 1'b0;
    logic                  min_max_select = 1'b0;
    lockq_pkg::bus_state_s bus = '0;
    lockq_pkg::queue_op_s  queue_op = '0;
    logic                  lk_o, lk_oe, lk_pu, qhi, qlo;
    logic            [7:0] taken;
    int                    failures = 0, compares = 0, seed = 32'he1c51510;
    int                    pref, ack, sec, gr, taken_m, cur, qp[$];
    always #10 clk = ~clk;
    lock_queue_status lock_queue_status_i (.clk(clk), .reset_n(reset_n), .lock_prefix(lock_prefix),
        .instr_done(instr_done), .grant_active(grant_active), .min_max_select(min_max_select), .bus(bus),
        .queue_op(queue_op), .bus_lock_n_o(lk_o), .bus_lock_n_oe(lk_oe), .bus_lock_weak_pu(lk_pu),
        .queue_state_hi(qhi), .queue_state_lo(qlo));
    queue_tracker queue_tracker_i (.clk(clk), .reset_n(reset_n), .queue_state_hi(qhi),
        .queue_state_lo(qlo), .taken_q(taken));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // the mode strap is set while reset is held, so it has passed the synchroniser by release
    task do_reset(input logic mode);
        min_max_select = mode;
        reset_n = 1'b0;
        {lock_prefix, instr_done, grant_active, bus, queue_op} = '0;
        repeat (6) @(posedge clk);
        #1 reset_n = 1'b1;
        {pref, ack, sec, gr, taken_m, cur} = '0;
        qp.delete();
    endtask
    // one model step per edge, then compare and drive new random inputs
    task run(input int n, input logic mode);
        repeat (n) begin
            @(posedge clk);
            if (cur == 2) taken_m = 0;
            else if (cur % 2 == 1) taken_m++;
            qp.push_back(queue_op.flush ? 2 : queue_op.first_byte ? 1 : queue_op.next_byte ? 3 : 0);
            cur = qp.pop_front();
            gr = grant_active;
            if (lock_prefix) pref = 1;
            else if (instr_done) pref = 0;
            // acknowledge lock: enter at a first T2, leave at a T2 once a cycle end was seen
            if (!ack) ack = !mode && bus.irq_ack_cycle && bus.t2;
            else if (sec && !mode && bus.irq_ack_cycle && bus.t2) {ack, sec} = '0;
            else if (bus.irq_ack_cycle && bus.cycle_end) sec = 1;
            #1;
            check(lk_o, gr ? 1 : !(pref || ack));
            check({lk_oe, lk_pu}, gr ? 1 : 2);
            check({qhi, qlo}, cur);
            check(taken, taken_m[7:0]);
            min_max_select = mode;
            lock_prefix = ($random(seed) % 16) == 0;
            instr_done = ($random(seed) % 6) == 0;
            grant_active = ($random(seed) % 8) == 0;
            bus = {($random(seed) % 4) == 0, ($random(seed) % 3) == 0, ($random(seed) % 4) == 0};
            queue_op = {($random(seed) % 5) == 0, ($random(seed) % 3) == 0, ($random(seed) % 3) == 0};
        end
    endtask
    initial begin
        do_reset(1'b1);
        run(300, 1'b1);
        do_reset(1'b0);
        run(1500, 1'b0);
        give_verdict;
    end
endmodule
